// file: link_state_pkg.sv
/*
 Shared constants for the target-side link state word and link parameters:
 register addresses, state word field positions, protocol parameter defaults
 and timing figures.
 Assumes a 10 MHz core clock and a separate clock for the bus sampling logic.
*/
`default_nettype none

package link_state_pkg;

   // ----------------------------------------------------------------
   // Register addresses selected by the master
   // ----------------------------------------------------------------
   localparam logic [7:0] state_word_addr   = 8'h82;
   localparam logic [7:0] base_addr_reg     = 8'h83;
   localparam logic [7:0] bus_rate_reg      = 8'h84;
   localparam logic [7:0] guard_time_reg    = 8'h85;
   localparam logic [7:0] resend_tmo_reg    = 8'h86;
   localparam logic [7:0] warm_reset_reg    = 8'h88;

   // ----------------------------------------------------------------
   // State word field positions
   // ----------------------------------------------------------------
   localparam int busy_bit        = 31;
   localparam int resp_bit        = 30;
   localparam int warm_cap_bit    = 27;
   localparam int continued_read_capability_bit   = 26;
   localparam int repeated_start_capability_bit   = 25;
   localparam int stretch_bit     = 24;
   localparam int protect_bit     = 23;
   localparam int length_msb      = 15;
   localparam int state_bytes     = 4;

   // ----------------------------------------------------------------
   // Protocol parameter defaults and limits
   // ----------------------------------------------------------------
   localparam logic [15:0] max_packet_default   = 16'h0110;
   localparam logic [15:0] max_packet_limit     = 16'hFFFF;
   localparam logic [1:0]  window_default       = 2'h1;
   localparam logic [1:0]  window_max           = 2'h2;
   localparam logic [4:0]  path_count_default   = 5'h01;
   localparam logic [4:0]  path_count_max       = 5'h10;
   localparam logic [3:0]  single_path_field    = 4'h0;
   localparam logic        chaining_default     = 1'b1;
   localparam logic [9:0]  resend_tmo_default   = 10'h00A;
   localparam logic [9:0]  resend_tmo_max       = 10'h3E8;
   localparam logic [2:0]  resend_limit_default = 3'h3;
   localparam logic [2:0]  resend_limit_max     = 3'h4;
   localparam logic [6:0]  target_addr_default  = 7'h30;
   localparam logic [31:0] bus_rate_khz_default = 32'h0000_03E8;
   localparam logic [31:0] guard_time_us        = 32'h0000_0032;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int clock_khz      = 10000;
   localparam int ms_cycles      = clock_khz;  // one millisecond
   localparam int warm_reset_len = 16;         // cycles of held reset

endpackage

`default_nettype wire

// file: bit_sync.sv
/*
 Two flip-flop synchroniser for a single level.
 Assumes the input is a level that stays for several destination clocks.
*/
`default_nettype none

module bit_sync
(
   // Destination clock
   input  wire logic clock,
   // Asynchronous level in, synchronised level out
   input  wire logic din,
   output var  logic dout
);

   logic meta_q;

   // ----------------------------------------------------------------
   // Two-stage capture; first stage read by the second only
   // ----------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      meta_q <= din;
      dout   <= meta_q;
   end

endmodule

`default_nettype wire

// file: pulse_sync.sv
/*
 Event crossing by toggle: a one-cycle pulse in the source domain becomes a
 one-cycle pulse in the destination domain.
 Assumes source pulses are spaced by at least three destination clocks.
*/
`default_nettype none

module pulse_sync
(
   // Source side
   input  wire logic src_clock,
   input  wire logic src_pulse,
   // Destination side
   input  wire logic dst_clock,
   output var  logic dst_pulse
);

   logic tog_q = 1'b0;
   logic meta_q;
   logic sync_q;
   logic last_q;

   // Toggle flips once per source event
   always_ff @(posedge src_clock)
   begin
      tog_q <= tog_q ^ src_pulse;
   end

   // Two-stage capture, then edge detect on the second stage
   always_ff @(posedge dst_clock)
   begin
      meta_q    <= tog_q;
      sync_q    <= meta_q;
      last_q    <= sync_q;
      dst_pulse <= sync_q ^ last_q;
   end

endmodule

`default_nettype wire

// file: link_state_regs.sv
/*
 Target-side I2C register front for the link state word and the fixed link
 parameters. A byte-level I2C target on the bus clock decodes the address,
 selects a register and returns it most significant byte first.
 Assumes open-drain scl and sda are resolved outside; the core signals busy,
 response ready and response length on the core clock.
*/
`default_nettype none

//
// Overview of operation
// R1: Busy flag at bit 31 during command
// R2: Response ready flag at bit 30
// R3: Fixed capability flags at bits 27..24
// R4: Bit 23 shows payload protection available
// R5: Bits 15..0 carry response length
// R6: Max packet default 0x110, cap 0xFFFF
// R7: Window default 1, limited to 1..2
// R8: Paths 1..16, single path field 0000
// R9: Chaining supported and flagged by default
// R10: Resend timeout default 10 ms, 1..1000
// R11: Acknowledge timeout shorter than resend timeout
// R12: Resend limit default 3, range 1..4
// R13: Answer at target address default 0x30
// R14: Top bus rate default 1000 kHz
// R15: Master waits 50 us after read
// R16: Guard kept across other target accesses
// R17: Write to warm reset register resets device
// R18: State word read-only at address 0x82
// R19: All-ones parameter read means unsupported
// R20: Reserved state bits read zero always
module link_state_regs
#(
   parameter logic [6:0]  target_addr_init  = link_state_pkg::target_addr_default,
   parameter logic [1:0]  window_init       = link_state_pkg::window_default,
   parameter logic [4:0]  path_count_init   = link_state_pkg::path_count_default,
   parameter logic [9:0]  resend_tmo_init   = link_state_pkg::resend_tmo_default,
   parameter logic [2:0]  resend_limit_init = link_state_pkg::resend_limit_default,
   parameter logic        warm_reset_cap    = 1'b1,
   parameter logic        protect_cap       = 1'b1
)
(
   // Core clock and reset
   input  wire logic        clock,
   input  wire logic        srst,
   // Core status
   input  wire logic        cmd_busy,
   input  wire logic        resp_ready,
   input  wire logic [15:0] resp_length,
   // Bus side clock, reset and pins
   input  wire logic        bus_clock,
   input  wire logic        bus_srst,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output var  logic        sda_oe_n,
   // Fixed link parameters to the protocol layers
   output var  logic [15:0] max_packet_size,
   output var  logic [1:0]  sliding_window_depth,
   output var  logic [4:0]  network_path_count,
   output var  logic [3:0]  network_path_field,
   output var  logic        chaining_enabled,
   output var  logic [9:0]  resend_timeout_ms,
   output var  logic [9:0]  ack_timeout_ms,
   output var  logic [2:0]  resend_attempt_limit,
   output var  logic [31:0] top_bus_rate_khz,
   // Warm reset request
   output var  logic        warm_reset
);

   import link_state_pkg::*;

   // ----------------------------------------------------------------
   // Core domain: state word capture
   // ----------------------------------------------------------------
   logic        busy_q;
   logic        resp_q;
   logic [15:0] len_q;
   logic [31:0] state_word;

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         busy_q <= 1'b0;
         resp_q <= 1'b0;
         len_q  <= 16'h0000;
      end
      else
      begin
         busy_q <= cmd_busy;    // R1
         resp_q <= resp_ready;  // R2
         len_q  <= resp_length; // R5
      end
   end

   // Word assembly; reserved bits tied low
   assign state_word = {busy_q, resp_q, 2'b00,                          // R1 R2 R20
                        warm_reset_cap, 1'b1, 1'b1, 1'b1,               // R3
                        protect_cap, 7'h00,                             // R4 R20
                        len_q};                                         // R5

   // ----------------------------------------------------------------
   // Core domain: parameter outputs, clamped into legal ranges
   // ----------------------------------------------------------------
   wire logic [1:0] win_legal  = (window_init == 2'h0) ? window_default :
                                 (window_init > window_max) ? window_max : window_init;
   wire logic [4:0] path_legal = (path_count_init == 5'h00) ? path_count_default :
                                 (path_count_init > path_count_max) ? path_count_max : path_count_init;
   wire logic [9:0] tmo_legal  = (resend_tmo_init == 10'h000) ? resend_tmo_default :
                                 (resend_tmo_init > resend_tmo_max) ? resend_tmo_max : resend_tmo_init;
   wire logic [2:0] rep_legal  = (resend_limit_init == 3'h0) ? resend_limit_default :
                                 (resend_limit_init > resend_limit_max) ? resend_limit_max : resend_limit_init;
   // Acknowledge side answers well ahead of the sender's resend timer
   wire logic [9:0] ack_tmo    = (tmo_legal > 10'h001) ? {1'b0, tmo_legal[9:1]} : 10'h000;

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         max_packet_size      <= max_packet_default;   // R6
         sliding_window_depth <= window_default;
         network_path_count   <= path_count_default;
         network_path_field   <= single_path_field;
         chaining_enabled     <= chaining_default;
         resend_timeout_ms    <= resend_tmo_default;
         ack_timeout_ms       <= resend_tmo_default >> 1;
         resend_attempt_limit <= resend_limit_default;
         top_bus_rate_khz     <= bus_rate_khz_default;
      end
      else
      begin
         max_packet_size      <= max_packet_default;   // R6
         sliding_window_depth <= win_legal;            // R7
         network_path_count   <= path_legal;           // R8
         network_path_field   <= single_path_field;    // R8
         chaining_enabled     <= chaining_default;     // R9
         resend_timeout_ms    <= tmo_legal;            // R10
         ack_timeout_ms       <= ack_tmo;              // R11
         resend_attempt_limit <= rep_legal;            // R12
         top_bus_rate_khz     <= bus_rate_khz_default; // R14
      end
   end

   // ----------------------------------------------------------------
   // Bus domain: pin synchronisers and condition detect
   // ----------------------------------------------------------------
   logic scl_s;
   logic sda_s;
   logic scl_d_q;
   logic sda_d_q;

   bit_sync u_scl_sync
   (
      .clock (bus_clock),
      .din   (scl_in),
      .dout  (scl_s)
   );

   bit_sync u_sda_sync
   (
      .clock (bus_clock),
      .din   (sda_in),
      .dout  (sda_s)
   );

   always_ff @(posedge bus_clock)
   begin
      scl_d_q <= scl_s;
      sda_d_q <= sda_s;
   end

   wire logic scl_rise  = scl_s & ~scl_d_q;
   wire logic scl_fall  = ~scl_s & scl_d_q;
   wire logic start_det = scl_s & scl_d_q & sda_d_q & ~sda_s;
   wire logic stop_det  = scl_s & scl_d_q & ~sda_d_q & sda_s;

   // ----------------------------------------------------------------
   // Bus domain: byte engine
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {idle_st, addr_st, addr_ack_st, wr_st, wr_ack_st, rd_st, rd_ack_st} bus_state_t;

   bus_state_t  st_q;
   logic [7:0]  shift_q;
   logic [2:0]  bit_q;
   logic [7:0]  reg_sel_q;
   logic        sel_valid_q;
   logic [1:0]  byte_q;
   logic        warm_pulse_q;
   logic [31:0] word_q;
   logic        got_bit_q;   // Keeps the START's own scl fall from ending a byte

   // State word is copied into the bus domain every bus clock; its fields
   // are quasi-static versus the bus, and each byte is taken as it is loaded to send.
   wire logic [31:0] rd_word   = (reg_sel_q == state_word_addr) ? word_q :   // R18
                                 (reg_sel_q == bus_rate_reg)    ? bus_rate_khz_default :
                                 (reg_sel_q == guard_time_reg)  ? guard_time_us :
                                 (reg_sel_q == resend_tmo_reg)  ? {22'h0, resend_tmo_default} :
                                 32'hFFFF_FFFF;                              // R19
   wire logic [7:0]  rd_byte   = rd_word[8*(3-byte_q) +: 8];
   wire logic        addr_hit  = (shift_q[7:1] == target_addr_init);         // R13

   always_ff @(posedge bus_clock)
   begin
      word_q <= state_word;
   end

   always_ff @(posedge bus_clock)
   begin
      if (bus_srst)
      begin
         st_q         <= idle_st;
         shift_q      <= 8'h00;
         bit_q        <= 3'h0;
         reg_sel_q    <= 8'h00;
         sel_valid_q  <= 1'b0;
         byte_q       <= 2'h0;
         sda_oe_n     <= 1'b1;
         warm_pulse_q <= 1'b0;
         got_bit_q    <= 1'b0;
      end
      else
      begin
         warm_pulse_q <= 1'b0;
         if (start_det)
         begin
            st_q     <= addr_st;
            bit_q     <= 3'h0;
            got_bit_q <= 1'b0;
            sda_oe_n  <= 1'b1;
         end
         else if (stop_det)
         begin
            st_q     <= idle_st;
            sda_oe_n <= 1'b1;
         end
         else
         begin
            unique case (st_q)
               idle_st:
                  sda_oe_n <= 1'b1;
               addr_st, wr_st:
                  if (scl_rise)
                  begin
                     shift_q <= {shift_q[6:0], sda_s};
                     bit_q     <= bit_q + 3'h1;
                     got_bit_q <= 1'b1;
                  end
                  else if (scl_fall && bit_q == 3'h0 && got_bit_q)
                  begin
                     got_bit_q <= 1'b0;
                     if (st_q == addr_st)
                     begin
                        if (addr_hit)                                        // R13
                        begin
                           sda_oe_n <= 1'b0;
                           byte_q   <= 2'h0;
                           st_q     <= addr_ack_st;
                        end
                        else
                           st_q <= idle_st;
                     end
                     else
                     begin
                        sda_oe_n <= 1'b0;
                        st_q     <= wr_ack_st;
                        if (!sel_valid_q)
                        begin
                           reg_sel_q   <= shift_q;
                           sel_valid_q <= 1'b1;
                           byte_q      <= 2'h0;
                           // Any write to the warm reset register resets
                           if (shift_q == warm_reset_reg && warm_reset_cap)
                              warm_pulse_q <= 1'b1;                          // R17
                        end
                        else if (reg_sel_q == warm_reset_reg && warm_reset_cap)
                           warm_pulse_q <= 1'b1;                             // R17
                        // Writes to read-only words are acknowledged and dropped
                     end
                  end
               addr_ack_st:
                  if (scl_fall)
                  begin
                     if (shift_q[0])
                     begin
                        st_q     <= rd_st;
                        shift_q  <= rd_byte;
                        sda_oe_n <= rd_byte[7];
                        bit_q    <= 3'h1;
                     end
                     else
                     begin
                        st_q        <= wr_st;
                        sel_valid_q <= 1'b0;
                        sda_oe_n    <= 1'b1;
                        bit_q       <= 3'h0;
                     end
                  end
               wr_ack_st:
                  if (scl_fall)
                  begin
                     sda_oe_n <= 1'b1;
                     bit_q    <= 3'h0;
                     st_q     <= wr_st;
                  end
               rd_st:
                  if (scl_fall)
                  begin
                     if (bit_q == 3'h0)
                     begin
                        sda_oe_n <= 1'b1;
                        st_q     <= rd_ack_st;
                     end
                     else
                     begin
                        sda_oe_n <= shift_q[3'h7 - bit_q];
                        bit_q    <= bit_q + 3'h1;
                     end
                  end
               rd_ack_st:
                  if (scl_rise)
                  begin
                     if (sda_s)
                        st_q <= idle_st;
                     else
                     begin
                        byte_q <= (byte_q == 2'(state_bytes - 1)) ? 2'h0 : byte_q + 2'h1;
                        st_q   <= addr_ack_st;
                        shift_q[0] <= 1'b1;
                     end
                  end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Warm reset: event crosses to core, then held for a fixed count
   // ----------------------------------------------------------------
   logic       warm_core;
   logic [4:0] warm_cnt_q;

   pulse_sync u_warm_sync
   (
      .src_clock (bus_clock),
      .src_pulse (warm_pulse_q),
      .dst_clock (clock),
      .dst_pulse (warm_core)
   );

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         warm_cnt_q <= 5'h00;
         warm_reset <= 1'b0;
      end
      else
      begin
         if (warm_core)
            warm_cnt_q <= 5'(warm_reset_len);                                // R17
         else if (warm_cnt_q != 5'h00)
            warm_cnt_q <= warm_cnt_q - 5'h01;
         warm_reset <= warm_core | (warm_cnt_q > 5'h01);
      end
   end

endmodule

`default_nettype wire

// file: link_state_properties.sv
/*
 Port checks for the link state block.
 Assumes a sync reset per clock domain.
*/
`default_nettype none

module link_state_properties
#(
   parameter logic [1:0] window_init       = link_state_pkg::window_default,
   parameter logic [4:0] path_count_init   = link_state_pkg::path_count_default,
   parameter logic [9:0] resend_tmo_init   = link_state_pkg::resend_tmo_default,
   parameter logic [2:0] resend_limit_init = link_state_pkg::resend_limit_default
)
(
   // Clocks and resets
   input wire logic        clock,
   input wire logic        srst,
   input wire logic        bus_clock,
   input wire logic        bus_srst,
   // Core status and pins
   input wire logic        cmd_busy,
   input wire logic        resp_ready,
   input wire logic        scl_in,
   input wire logic        sda_oe_n,
   // Parameters and warm reset
   input wire logic [15:0] max_packet_size,
   input wire logic [1:0]  sliding_window_depth,
   input wire logic [4:0]  network_path_count,
   input wire logic [3:0]  network_path_field,
   input wire logic        chaining_enabled,
   input wire logic [9:0]  resend_timeout_ms,
   input wire logic [9:0]  ack_timeout_ms,
   input wire logic [2:0]  resend_attempt_limit,
   input wire logic [31:0] top_bus_rate_khz,
   input wire logic        warm_reset
);
   import link_state_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------------------------------
   // Fixed parameters, checked every core cycle
   // ----------------------------------------------------------------
   property p_packet;
      @(posedge clock) disable iff (srst) max_packet_size == max_packet_default;
   endproperty
   a_packet: assert property (p_packet) else $error("packet size wrong");
   property p_window;
      @(posedge clock) disable iff (srst) sliding_window_depth inside {[1:2]} && sliding_window_depth == window_init;
   endproperty
   a_window: assert property (p_window) else $error("window depth wrong");
   property p_paths;
      @(posedge clock) disable iff (srst) network_path_count == path_count_init &&
         (network_path_count != 5'h01 || network_path_field == single_path_field);
   endproperty
   a_paths: assert property (p_paths) else $error("path count or field wrong");
   property p_chain;
      @(posedge clock) disable iff (srst) chaining_enabled == chaining_default;
   endproperty
   a_chain: assert property (p_chain) else $error("chaining flag wrong");
   property p_resend;
      @(posedge clock) disable iff (srst) resend_timeout_ms inside {[1:1000]} && resend_timeout_ms == resend_tmo_init;
   endproperty
   a_resend: assert property (p_resend) else $error("resend timeout wrong");
   // Receiver must acknowledge before the sender gives up
   property p_ack;
      @(posedge clock) disable iff (srst) ack_timeout_ms != 10'h000 && ack_timeout_ms < resend_timeout_ms;
   endproperty
   a_ack: assert property (p_ack) else $error("ack timeout not shorter");
   property p_limit;
      @(posedge clock) disable iff (srst) resend_attempt_limit == resend_limit_init;
   endproperty
   a_limit: assert property (p_limit) else $error("resend limit wrong");
   property p_rate;
      @(posedge clock) disable iff (srst) top_bus_rate_khz == bus_rate_khz_default;
   endproperty
   a_rate: assert property (p_rate) else $error("bus rate wrong");

   // ----------------------------------------------------------------
   // Warm reset pulse and bus timing
   // ----------------------------------------------------------------
   property p_warm;
      @(posedge clock) disable iff (srst) $rose(warm_reset) |-> warm_reset [*8];
   endproperty
   a_warm: assert property (p_warm) else $error("warm reset pulse too short");
   // Data may only change while scl is low, else a false start or stop
   property p_sda_edge;
      @(posedge bus_clock) disable iff (bus_srst) $changed(sda_oe_n) |-> !scl_in;
   endproperty
   a_sda_edge: assert property (p_sda_edge) else $error("sda moved with scl high");
   c_warm: cover property (@(posedge clock) $rose(warm_reset));
   c_ack: cover property (@(posedge bus_clock) $fell(sda_oe_n));
   c_busy: cover property (@(posedge clock) cmd_busy && resp_ready);
endmodule

bind link_state_regs link_state_properties i_chk (.*);

`default_nettype wire

// file: i2c_host_model.sv
/*
 I2C master model.
 Assumes pull-ups and an open-drain target.
*/
`default_nettype none

module i2c_host_model
(
   // Bus sampling clock and target drive
   input  wire logic bus_clock,
   input  wire logic sda_oe_n,
   // Bus lines
   output var  logic scl,
   output wire logic sda
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int half    = 11;   // About 870 kHz, under the top rate
   localparam int guard_n = 1043; // 50 us of bus clocks
   logic sda_q = 1'b1;

   // Wired-and of both drivers, pull-up when released
   assign sda = sda_q & sda_oe_n;
   initial scl = 1'b1;

   task automatic tick(input int n);
      repeat (n) @(negedge bus_clock);
   endtask
   task automatic start();
      sda_q = 1'b1;
      tick(half);
      scl = 1'b1;
      tick(half);
      sda_q = 1'b0;
      tick(half);
      scl = 1'b0;
      tick(2);
   endtask
   // Guard time follows every stop, whoever is addressed next
   task automatic stop();
      sda_q = 1'b0;
      tick(half);
      scl = 1'b1;
      tick(half);
      sda_q = 1'b1;
      tick(guard_n);
   endtask
   task automatic bit_io(input logic b, output logic r);
      sda_q = b;
      tick(half);
      scl = 1'b1;
      tick(half);
      r = sda;
      scl = 1'b0;
      tick(2);
   endtask
   task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack_out);
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], q[i]);
      bit_io(ack_in, ack_out);
   endtask
endmodule

`default_nettype wire

// file: tb.sv
/*
 Bench for the link state block with an I2C master model.
 Assumes package and checker compiled first.
*/
`default_nettype none

module tb;
   import link_state_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clock = 1'b0;
   logic        srst = 1'b1;
   logic        bus_clock = 1'b0;
   logic        bus_srst = 1'b1;
   logic        cmd_busy = 1'b0;
   logic        resp_ready = 1'b0;
   logic [15:0] resp_length = 16'h0000;
   logic        scl, sda, sda_oe_n, chaining_enabled, warm_reset, k_bit;
   logic        warm_seen = 1'b0;
   logic [15:0] max_packet_size;
   logic [1:0]  sliding_window_depth;
   logic [4:0]  network_path_count;
   logic [3:0]  network_path_field;
   logic [9:0]  resend_timeout_ms, ack_timeout_ms;
   logic [2:0]  resend_attempt_limit;
   logic [31:0] top_bus_rate_khz, word;
   logic [31:0] seed = 32'h68A6;
   logic [7:0]  q_byte;
   int          bad_count = 0;
   int          checked = 0;

   // ----------------------------------------------------------------
   // Clocks, design and master model
   // ----------------------------------------------------------------
   always #50 clock = ~clock;
   // Offset keeps bus edges off core edges
   always
   begin
      if ($time == 0) #3.7;
      #24 bus_clock = ~bus_clock;
   end
   // Sticky copy of the short warm reset pulse
   always @(posedge clock) if (warm_reset) warm_seen <= 1'b1;

   link_state_regs i_dut (.*, .scl_in(scl), .sda_in(sda));
   i2c_host_model i_host (.*);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] exp_state(input logic b, input logic r, input logic [15:0] l);
      return {b, r, 2'b00, 4'hF, 1'b1, 7'h00, l};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic select(input logic [7:0] a);
      i_host.start();
      i_host.xfer({target_addr_default, 1'b0}, 1'b1, q_byte, k_bit);
      check(32'(k_bit), 32'h0);
      i_host.xfer(a, 1'b1, q_byte, k_bit);
   endtask
   task automatic read_reg(input logic [7:0] a, output logic [31:0] w);
      select(a);
      i_host.stop();
      i_host.start();
      i_host.xfer({target_addr_default, 1'b1}, 1'b1, q_byte, k_bit);
      for (int i = 0; i < 4; i++)
      begin
         i_host.xfer(8'hFF, i == 3, q_byte, k_bit);
         w = {w[23:0], q_byte};
      end
      i_host.stop();
   endtask
   task automatic stop_test();
      $display("checked=%0d bad_count=%0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial
   begin
      repeat (10) @(negedge clock);
      srst = 1'b0;
      @(negedge bus_clock);
      bus_srst = 1'b0;
      repeat (8) @(negedge bus_clock);
      check(32'(max_packet_size), 32'h0110);
      check(32'({sliding_window_depth, network_path_count, network_path_field, chaining_enabled}), 32'h421);
      check(32'({resend_timeout_ms, resend_attempt_limit}), 32'({10'd10, 3'd3}));
      check(32'(ack_timeout_ms < resend_timeout_ms), 32'h1);
      check(top_bus_rate_khz, 32'h3E8);
      $display("test params done");
      for (int n = 0; n < 7; n++)
      begin
         @(negedge clock);
         seed = lfsr(seed);
         {cmd_busy, resp_ready} = (n < 4) ? 2'(n) : seed[1:0];
         resp_length = (n == 0) ? 16'hFFFF : (n == 1) ? 16'h0000 : seed[23:8];
         read_reg(state_word_addr, word);
         check(word, exp_state(cmd_busy, resp_ready, resp_length));
      end
      $display("test state word done");
      select(state_word_addr);
      i_host.xfer(8'h00, 1'b1, q_byte, k_bit);
      i_host.stop();
      read_reg(state_word_addr, word);
      check(word, exp_state(cmd_busy, resp_ready, resp_length));
      read_reg(bus_rate_reg, word);
      check(word, 32'h3E8);
      read_reg(8'h87, word);
      check(word, 32'hFFFF_FFFF);
      i_host.start();
      i_host.xfer({target_addr_default + 7'h01, 1'b0}, 1'b1, q_byte, k_bit);
      i_host.stop();
      check(32'(k_bit), 32'h1);
      $display("test access done");
      check(32'(warm_seen), 32'h0);
      select(warm_reset_reg);
      i_host.stop();
      check(32'(warm_seen), 32'h1);
      $display("test warm reset done");
      stop_test();
   end
   // Cut a hang short well beyond the expected run
   initial
   begin
      repeat (60000) @(posedge clock);
      bad_count++;
      stop_test();
   end
endmodule

`default_nettype wire
